//--- logic/cmo_pkg.sv
// Package for the misc/output instruction decoder.
// Assumes a 10-bit instruction word presented one per enabled cycle.
package cmo_pkg;
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned ACC_W = 4;
  localparam int unsigned PC_W = 12;
  localparam int unsigned FSEL_W = 2;
  // File-select load: upper eight bits fixed, low two immediate
  localparam logic [7:0] OPC_LOAD_FSEL_HI = 8'h12;
  localparam int unsigned FSEL_IMM_LSB = 0;
  localparam logic [INSTR_W-1:0] OPC_NOP = 10'h000;
  localparam logic [INSTR_W-1:0] OPC_OUT_SINGLE = 10'h21f;
  // Port-zero opcode not fixed by the encoding at hand; a parameter default
  localparam logic [INSTR_W-1:0] OPC_OUT_P0_DEF = 10'h220;
  localparam logic [FSEL_W-1:0] FSEL_RST = 2'h0;
  localparam logic [PC_W-1:0] PC_RST = 12'h000;
  localparam logic KEY_RST = 1'b0;
  localparam logic [ACC_W-1:0] P0_RST = 4'h0;
  localparam int unsigned EXEC_CYCLES = 1;
  typedef enum logic [2:0] {
    CMO_OP_NONE, CMO_OP_LOAD_FSEL, CMO_OP_NOP, CMO_OP_OUT_SINGLE, CMO_OP_OUT_P0
  } cmo_op_t;
endpackage

//--- logic/cmo_latch.sv
// Enabled load register with synchronous reset.
// Assumes one clock domain, synchronous active-high reset.
module cmo_latch #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  if (WIDTH < 1) begin : g_bad_width
    $error("latch width must be at least one");
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= RST_VAL;
    end else if (clk_en && load) begin
      q <= d;
    end
  end
endmodule // cmo_latch

//--- logic/cmo_decode.sv
// Decode and execute of file-select load, no-op and two port outputs.
// Assumes the fetch side presents instr with instr_valid, one word per cycle.
// Function
// (RQ1) File-select load writes its two-bit immediate into file select in one cycle
// (RQ2) All-zero opcode advances program counter by one, nothing else changes
// (RQ3) Single-bit output copies accumulator bit zero to key-on latch; carry, skip untouched
// (RQ4) Port-zero output copies four accumulator bits to port-zero latch; no carry, skip
module cmo_decode
  import cmo_pkg::*;
#(
  parameter logic [cmo_pkg::INSTR_W-1:0] OPC_OUT_P0 = cmo_pkg::OPC_OUT_P0_DEF
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [cmo_pkg::INSTR_W-1:0] instr,
  input wire logic [cmo_pkg::ACC_W-1:0] acc,
  input wire logic carry_flag_in,
  output logic [cmo_pkg::FSEL_W-1:0] file_select,
  output logic [cmo_pkg::PC_W-1:0] pc,
  output logic key_on_port,
  output logic [cmo_pkg::ACC_W-1:0] port_zero,
  output logic carry_flag,
  output logic skip_next,
  output logic decode_hit
);
  import cmo_pkg::*;

  // Opcode parameter must not shadow a fixed encoding
  if (OPC_OUT_P0 == OPC_NOP) begin : g_p0_is_nop
    $error("OPC_OUT_P0 equals the no-op encoding");
  end
  if (OPC_OUT_P0 == OPC_OUT_SINGLE) begin : g_p0_is_single
    $error("OPC_OUT_P0 equals the single-bit output encoding");
  end
  if (OPC_OUT_P0[INSTR_W-1:2] == OPC_LOAD_FSEL_HI) begin : g_p0_is_fsel
    $error("OPC_OUT_P0 falls in the file-select load family");
  end
  if (FSEL_IMM_LSB + FSEL_W > INSTR_W) begin : g_imm_range
    $error("file-select immediate lies outside the word");
  end

  cmo_op_t op;
  wire logic is_load_fsel;
  wire logic is_nop;
  wire logic is_out_single;
  wire logic is_out_p0;
  wire logic step;
  logic [FSEL_W-1:0] file_select_ff;
  logic [PC_W-1:0] pc_ff;
  logic carry_flag_ff;
  logic [PC_W-1:0] nxt_pc;

  assign step = clk_en && instr_valid;
  assign is_load_fsel = instr[INSTR_W-1:2] == OPC_LOAD_FSEL_HI; // RQ1
  assign is_nop = instr == OPC_NOP; // RQ2
  assign is_out_single = instr == OPC_OUT_SINGLE; // RQ3
  assign is_out_p0 = instr == OPC_OUT_P0; // RQ4
  assign op = is_load_fsel ? CMO_OP_LOAD_FSEL :
              is_nop ? CMO_OP_NOP :
              is_out_single ? CMO_OP_OUT_SINGLE :
              is_out_p0 ? CMO_OP_OUT_P0 : CMO_OP_NONE;
  assign decode_hit = instr_valid && (op != CMO_OP_NONE);
  // Every decoded op is one word, so the counter steps by one
  assign nxt_pc = pc_ff + {{(PC_W-1){1'b0}}, 1'b1}; // RQ2

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      file_select_ff <= FSEL_RST;
      pc_ff <= PC_RST;
      carry_flag_ff <= 1'b0;
    end else if (clk_en) begin
      carry_flag_ff <= carry_flag_in; // Carry passes through untouched
      if (step && op == CMO_OP_LOAD_FSEL) begin
        file_select_ff <= instr[FSEL_IMM_LSB +: FSEL_W]; // RQ1
      end
      if (step && op != CMO_OP_NONE) begin
        pc_ff <= nxt_pc; // RQ2
      end
    end
  end

  cmo_latch #(.WIDTH(1), .RST_VAL(KEY_RST)) u_key_latch (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .load(step && op == CMO_OP_OUT_SINGLE), // RQ3
    .d(acc[0]),
    .q(key_on_port)
  );

  cmo_latch #(.WIDTH(ACC_W), .RST_VAL(P0_RST)) u_p0_latch (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .load(step && op == CMO_OP_OUT_P0), // RQ4
    .d(acc),
    .q(port_zero)
  );

  assign file_select = file_select_ff;
  assign pc = pc_ff;
  assign carry_flag = carry_flag_ff;
  assign skip_next = 1'b0; // RQ3 RQ4

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_fsel_issue;
    clk_en && instr_valid && is_load_fsel;
  endsequence

  sequence s_nop_issue;
    step && is_nop;
  endsequence

  sequence s_key_issue;
    step && is_out_single;
  endsequence

  sequence s_p0_issue;
    step && is_out_p0;
  endsequence

  sequence s_refused_issue;
    step && !decode_hit;
  endsequence

  sequence s_idle_cycle;
    clk_en && !instr_valid;
  endsequence

  // Two no-ops back to back
  sequence s_two_nops;
    s_nop_issue ##1 s_nop_issue;
  endsequence

  a_fsel_load_value: assert property ( // RQ1
    s_fsel_issue |=> file_select == $past(instr[1:0]))
    else $error("file select not loaded from immediate");

  a_fsel_holds_else: assert property ( // RQ1
    !(clk_en && instr_valid && is_load_fsel) |=> $stable(file_select))
    else $error("file select changed without its load");

  a_nop_pc_step: assert property ( // RQ2
    (clk_en && instr_valid && is_nop) |=> pc == $past(pc) + 12'h001)
    else $error("no-op did not add one to the counter");

  a_nop_ports_kept: assert property ( // RQ2
    (clk_en && instr_valid && is_nop) |=>
      $stable(file_select) && $stable(key_on_port) && $stable(port_zero))
    else $error("no-op disturbed other state");

  a_key_copy_bit: assert property ( // RQ3
    (clk_en && instr_valid && is_out_single) |=> key_on_port == $past(acc[0]))
    else $error("key-on latch missed accumulator bit zero");

  a_key_carry_kept: assert property ( // RQ3
    (clk_en && instr_valid && is_out_single) |=>
      carry_flag == $past(carry_flag_in) && !skip_next)
    else $error("single-bit output touched carry or skip");

  a_p0_copy_acc: assert property ( // RQ4
    (clk_en && instr_valid && is_out_p0) |=> port_zero == $past(acc))
    else $error("port zero not loaded from accumulator");

  a_p0_only_on_op: assert property ( // RQ4
    !(clk_en && instr_valid && is_out_p0) |=> $stable(port_zero))
    else $error("port zero changed without its instruction");

  a_freeze_no_enable: assert property ( // RQ2
    !clk_en |=> $stable(pc) && $stable(file_select))
    else $error("state moved while clock enable low");

  a_fsel_pc_step: assert property ( // RQ1
    s_fsel_issue |=> pc == $past(pc) + 12'h001)
    else $error("file-select load did not add one to the counter");

  a_fsel_ports_kept: assert property ( // RQ1
    s_fsel_issue |=> $stable(key_on_port) && $stable(port_zero) && !skip_next)
    else $error("file-select load disturbed the port latches");

  a_nop_carry_kept: assert property ( // RQ2
    s_nop_issue |=> carry_flag == $past(carry_flag_in) && !skip_next)
    else $error("no-op altered carry or skip");

  a_nop_pair_step: assert property ( // RQ2
    s_two_nops |=> pc == $past(pc, 2) + 12'h002)
    else $error("two no-ops did not add two to the counter");

  a_idle_pc_kept: assert property ( // RQ2
    s_idle_cycle |=> $stable(pc) && $stable(file_select))
    else $error("state moved with no instruction presented");

  a_refused_kept: assert property ( // RQ2
    s_refused_issue |=> $stable(pc) && $stable(file_select) &&
      $stable(key_on_port) && $stable(port_zero))
    else $error("unknown opcode changed state");

  a_hit_needs_valid: assert property ( // RQ2
    !instr_valid |-> !decode_hit)
    else $error("decode flagged with no instruction presented");

  a_reset_clears: assert property ( // RQ2
    disable iff (1'b0) reset |=> pc == PC_RST && file_select == FSEL_RST &&
      key_on_port == KEY_RST && port_zero == P0_RST && !carry_flag)
    else $error("reset did not clear the decoder state");

  a_key_pc_step: assert property ( // RQ3
    s_key_issue |=> pc == $past(pc) + 12'h001 && $stable(file_select))
    else $error("single-bit output did not step the counter alone");

  a_key_only_on_op: assert property ( // RQ3
    !(step && is_out_single) |=> $stable(key_on_port))
    else $error("key-on latch changed without its instruction");

  a_p0_pc_step: assert property ( // RQ4
    s_p0_issue |=> pc == $past(pc) + 12'h001 && $stable(file_select))
    else $error("port-zero output did not step the counter alone");

  a_p0_carry_kept: assert property ( // RQ4
    s_p0_issue |=> carry_flag == $past(carry_flag_in) && !skip_next)
    else $error("port-zero output touched carry or skip");

  a_freeze_latches: assert property ( // RQ3 RQ4
    !clk_en |=> $stable(key_on_port) && $stable(port_zero) && $stable(carry_flag))
    else $error("latches moved while clock enable low");
endmodule // cmo_decode

//--- test/cmo_port_pins.sv
// Partner model: output pins that follow the port latches.
// Assumes push-pull pins driven straight from the latch outputs.
module cmo_port_pins (
  input wire logic key_on_port,
  input wire logic [3:0] port_zero,
  output logic key_pin,
  output logic [3:0] p0_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  assign key_pin = key_on_port;
  assign p0_pin = port_zero;
endmodule // cmo_port_pins

//--- test/testbench.sv
// Self-checking bench: random ops, queued expectations, checking monitor.
// Assumes one clock, synchronous reset, results one cycle after the edge.
module testbench;
  import cmo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset = 1, clk_en = 0, instr_valid = 0, carry_flag_in = 0;
  logic [9:0] instr = '0;
  logic [3:0] acc = '0, e_p0 = '0, a;
  logic [1:0] file_select, e_fs = '0;
  logic [11:0] pc, e_pc = '0;
  logic [3:0] port_zero, p0_pin;
  logic key_on_port, carry_flag, skip_next, e_key = 0, e_cy = 0, decode_hit, key_pin;
  logic [20:0] exp_q[$];
  logic hit_q[$];
  wire logic [20:0] got_v = {skip_next, carry_flag, file_select, pc, key_pin, p0_pin};
  int miscompares = 0, cmp_count = 0, sel;
  initial forever #5 sys_clk = ~sys_clk;
  cmo_decode dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .acc(acc), .carry_flag_in(carry_flag_in),
    .file_select(file_select), .pc(pc), .key_on_port(key_on_port), .port_zero(port_zero),
    .carry_flag(carry_flag), .skip_next(skip_next), .decode_hit(decode_hit));
  cmo_port_pins pins (.key_on_port(key_on_port), .port_zero(port_zero), .key_pin(key_pin),
    .p0_pin(p0_pin));
  task compare(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task compare_hit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected hit at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    #2;
    if (exp_q.size() > 0) compare(got_v, exp_q.pop_front());
    if (hit_q.size() > 0) compare_hit(decode_hit, hit_q.pop_front());
  end
  initial begin
    #10000;
    miscompares++;
    results;
  end
  initial begin
    void'($urandom(22));
    repeat (8) @(posedge sys_clk);
    #1;
    reset = 0;
    exp_q.push_back('0);
    $display("test reset done");
    repeat (300) begin
      sel = $urandom % 7;
      a = 4'($urandom);
      acc = a;
      carry_flag_in = 1'($urandom);
      clk_en = (sel != 5);
      instr_valid = (sel != 6);
      case (sel)
        0: instr = {OPC_LOAD_FSEL_HI, a[3:2]};
        2, 5: instr = OPC_OUT_SINGLE;
        3: instr = OPC_OUT_P0_DEF;
        4: instr = 10'h3ff;
        default: instr = OPC_NOP;
      endcase
      hit_q.push_back(sel != 4 && sel != 6);
      if (clk_en) begin
        e_cy = carry_flag_in;
        if (sel < 4) e_pc++;
        if (sel == 0) e_fs = a[3:2];
        if (sel == 2) e_key = a[0];
        if (sel == 3) e_p0 = a;
      end
      @(posedge sys_clk);
      #1;
      exp_q.push_back({1'b0, e_cy, e_fs, e_pc, e_key, e_p0});
    end
    @(posedge sys_clk);
    #3;
    $display("test random done");
    results;
  end
endmodule // testbench
